/* File: verilog/psie_defines.svh */
`ifndef PSIE_DEFINES_SVH
`define PSIE_DEFINES_SVH
// ==========================================
// Error codes
`define PSIE_ERR_HOME      8'h80
`define PSIE_ERR_JOG       8'h81
`define PSIE_ERR_VEL       8'h82
`define PSIE_ERR_FORCE     8'h83
`define PSIE_ERR_PROG      8'h84
`define PSIE_ERR_ABORT     8'h85
`define PSIE_ERR_POSV      8'h86
`define PSIE_ERR_DRIVE     8'h87
`define PSIE_ERR_SYNC_CM   8'h8C
`define PSIE_ERR_SYNC_JMP  8'h8D
`define PSIE_ERR_FLASH     8'h90
`define PSIE_ERR_HALT      8'h91
`define PSIE_ERR_TIMEOUT   8'h92
`define PSIE_ERR_DIVZERO   8'h93
`define PSIE_ERR_DIVOVF    8'h94
`define PSIE_ERR_LLSTOP    8'h9A
`define PSIE_ERR_NONE      8'h00
// ==========================================
// Motion command codes
`define PSIE_CMD_VEL       8'h22
`define PSIE_CMD_FORCE_AN  8'h24
`define PSIE_CMD_FORCE_DV  8'h34
// ==========================================
// Timing
`define PSIE_CLK_MHZ       50
`define PSIE_LL_BUDGET_US  300
// Logic-cycle budget in clocks, 300 us times 50 MHz exactly (longest time)
`define PSIE_LL_BUDGET_CYC (`PSIE_LL_BUDGET_US * `PSIE_CLK_MHZ)
// ==========================================
// Register map (word index)
`define PSIE_REG_AXERR     4'h0
`define PSIE_REG_MODERR    4'h1
`define PSIE_REG_STAT      4'h2
`define PSIE_REG_CTRL      4'h3
`endif

/* File: verilog/psie_pkg.sv */
`default_nettype none
package psie_pkg;
	// Per-axis state seen at program-run time
	typedef struct packed {
		logic       homing;      // Home cycle running
		logic       jogging;     // Jog from host or user logic
		logic [7:0] active_cmd;  // Command in effect
		logic       cmd_valid;   // active_cmd meaningful
		logic       prog_active; // Program active status
		logic       abort_req;   // Abort-all request
		logic       moving;      // Moving status
		logic       pos_valid;   // Position valid status
		logic       drive_en;    // Drive enabled status
	} psie_axis_type;
	// User-logic fatal event group
	typedef struct packed {
		logic halt_wr;    // Halt variable written
		logic div_zero;   // Divide/modulus by zero
		logic div_ovf;    // Quotient past 32 bits
	} psie_ll_type;
endpackage
`default_nettype wire

/* File: verilog/psie_checker.sv */
`default_nettype none
`include "psie_defines.svh"
// ==========================================
// Program-start check for one axis
module psie_checker
	import psie_pkg::*;
(
	input  wire logic          sys_clk,
	input  wire logic          reset,
	input  wire psie_axis_type ax,        // Axis state
	input  wire logic          run_req,   // Program-run request pulse
	output var  logic          refuse_q,  // Refusal pulse
	output var  logic          start_q,   // Accepted start pulse
	output var  logic [7:0]    code_q     // Posted code on refusal
);
	// ==========================================
	// Priority decode of refusal cause
	function automatic logic [7:0] cause(input psie_axis_type a);
		if (a.homing) return `PSIE_ERR_HOME;
		else if (a.jogging) return `PSIE_ERR_JOG;
		else if (a.cmd_valid && a.active_cmd == `PSIE_CMD_VEL) return `PSIE_ERR_VEL;
		else if (a.cmd_valid && (a.active_cmd == `PSIE_CMD_FORCE_DV ||
			a.active_cmd == `PSIE_CMD_FORCE_AN)) return `PSIE_ERR_FORCE;
		else if (a.abort_req) return `PSIE_ERR_ABORT;
		else if (a.prog_active) return `PSIE_ERR_PROG;
		else if (a.moving) return `PSIE_ERR_ABORT;
		else if (!a.pos_valid) return `PSIE_ERR_POSV;
		else if (!a.drive_en) return `PSIE_ERR_DRIVE;
		else return `PSIE_ERR_NONE;
	endfunction
	wire logic [7:0] why = cause(ax); // Decoded cause
	// Registered verdict, one cycle after request
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			refuse_q <= 1'b0;
			start_q  <= 1'b0;
			code_q   <= `PSIE_ERR_NONE;
		end else begin
			refuse_q <= run_req && (why != `PSIE_ERR_NONE);
			start_q  <= run_req && (why == `PSIE_ERR_NONE);
			code_q   <= run_req ? why : code_q;
		end
	end
endmodule
`default_nettype wire

/* File: verilog/psie_top.sv */
`default_nettype none
`include "psie_defines.svh"
// ==========================================
// Program-start interlock and fatal error reporting
module psie_top
	import psie_pkg::*;
#(
	parameter int NAXES      = 2,
	parameter int LL_BUDGET  = `PSIE_LL_BUDGET_CYC // Shorten in simulation
)(
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	// Wishbone classic slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [3:0]           wb_adr_i,  // Word index
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output var  logic [31:0]          wb_dat_o,
	output var  logic                 wb_ack_o,
	// Axis state and requests
	input  wire psie_axis_type [NAXES-1:0] axis,
	input  wire logic [NAXES-1:0]     run_req,     // Program-run requests
	input  wire logic [NAXES-1:0]     sync_cm_err, // Sync missed at contoured move
	input  wire logic [NAXES-1:0]     sync_jmp_err,// Sync missed at jump
	input  wire logic                 flash_fail,  // Flash programming failed
	input  wire psie_ll_type          ll_evt,      // User-logic fatal events
	input  wire logic                 ll_cycle_start, // Logic cycle begins
	input  wire logic                 ll_cycle_done,  // Logic cycle ends
	output var  logic [NAXES-1:0]     prog_start_q, // Accepted start pulses
	output var  logic [NAXES-1:0]     fast_stop_q,  // Halt motion level
	output var  logic                 mod_err_q     // Module error present
);
	// ==========================================
	// Per-axis checkers
	logic [NAXES-1:0] refuse;        // Refusal pulses
	logic [NAXES-1:0] start;         // Start pulses
	logic [7:0]       rcode [NAXES]; // Refusal codes
	for (genvar g = 0; g < NAXES; g++) begin : g_ax
		psie_checker u_chk (
			.sys_clk  (sys_clk),
			.reset    (reset),
			.ax       (axis[g]),
			.run_req  (run_req[g]),
			.refuse_q (refuse[g]),
			.start_q  (start[g]),
			.code_q   (rcode[g])
		);
	end
	// ==========================================
	// User-logic execution timer
	logic [31:0] ll_cnt_q;   // Cycles in current logic pass
	logic        ll_run_q;   // Logic pass running
	logic        ll_to_q;    // Timeout latched for this pass
	wire  logic  ll_timeout = ll_run_q && !ll_to_q && (ll_cnt_q >= 32'(LL_BUDGET));
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ll_cnt_q <= 32'h0;
			ll_run_q <= 1'b0;
			ll_to_q  <= 1'b0;
		end else if (ll_cycle_start) begin
			ll_cnt_q <= 32'h0;
			ll_run_q <= 1'b1;
			ll_to_q  <= 1'b0;
		end else begin
			ll_cnt_q <= ll_run_q ? ll_cnt_q + 32'h1 : ll_cnt_q;
			ll_run_q <= ll_run_q && !ll_cycle_done;
			ll_to_q  <= ll_to_q || ll_timeout;
		end
	end
	// ==========================================
	// Module-level error code, priority 91..94 then 90
	wire logic       fatal = ll_evt.halt_wr || ll_timeout || ll_evt.div_zero
		|| ll_evt.div_ovf;
	wire logic [7:0] mcode = ll_evt.halt_wr ? `PSIE_ERR_HALT :
		ll_timeout ? `PSIE_ERR_TIMEOUT :
		ll_evt.div_zero ? `PSIE_ERR_DIVZERO :
		ll_evt.div_ovf ? `PSIE_ERR_DIVOVF :
		flash_fail ? `PSIE_ERR_FLASH : `PSIE_ERR_NONE;
	// ==========================================
	// Registers: codes, fast stop, clear control
	logic [7:0] axerr_q [NAXES]; // Last axis error code
	logic [7:0] moderr_q;        // Last module error code
	logic       stop_all_q;      // Fast stop all axes
	// Write lands at the edge where the master sees ack, never earlier
	wire  logic wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
	wire  logic clr = wr && (wb_adr_i == `PSIE_REG_CTRL) && wb_dat_i[0];
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			moderr_q   <= `PSIE_ERR_NONE;
			stop_all_q <= 1'b0;
		end else begin
			// New error wins over software clear
			moderr_q   <= (mcode != `PSIE_ERR_NONE) ? mcode : (clr ? `PSIE_ERR_NONE : moderr_q);
			stop_all_q <= fatal || (stop_all_q && !clr);
		end
	end
	for (genvar a = 0; a < NAXES; a++) begin : g_err
		always_ff @(posedge sys_clk) begin
			if (reset) begin
				axerr_q[a] <= `PSIE_ERR_NONE;
			end else if (fatal) begin
				axerr_q[a] <= `PSIE_ERR_LLSTOP;
			end else if (sync_jmp_err[a]) begin
				axerr_q[a] <= `PSIE_ERR_SYNC_JMP;
			end else if (sync_cm_err[a]) begin
				axerr_q[a] <= `PSIE_ERR_SYNC_CM;
			end else if (refuse[a]) begin
				axerr_q[a] <= rcode[a];
			end else if (clr) begin
				axerr_q[a] <= `PSIE_ERR_NONE;
			end
		end
	end
	// ==========================================
	// Outputs: status-only errors never touch motion
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prog_start_q <= '0;
			fast_stop_q  <= '0;
			mod_err_q    <= 1'b0;
		end else begin
			prog_start_q <= start & ~{NAXES{stop_all_q}};
			fast_stop_q  <= {NAXES{stop_all_q || fatal}};
			mod_err_q    <= (moderr_q != `PSIE_ERR_NONE);
		end
	end
	// ==========================================
	// Wishbone read mux, ack in one cycle
	wire logic [31:0] rd = (wb_adr_i == `PSIE_REG_AXERR) ? {24'h0, axerr_q[0]} :
		(wb_adr_i == `PSIE_REG_MODERR) ? {24'h0, moderr_q} :
		(wb_adr_i == `PSIE_REG_STAT) ? {31'h0, stop_all_q} :
		(wb_adr_i == `PSIE_REG_CTRL) ? (NAXES > 1 ? {24'h0, axerr_q[NAXES-1]} : 32'h0) : 32'h0;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= rd;
		end
	end
endmodule
`default_nettype wire

/* File: tb/psie_top_properties.sv */
`default_nettype none
// ==========================================
// Port-level checks of the start interlock, halt fast stop and flash flag
module psie_props
	import psie_pkg::*;
#(
	parameter int NAXES = 2
)(
	input wire logic                      sys_clk,
	input wire logic                      reset,
	input wire psie_axis_type [NAXES-1:0] axis,
	input wire logic [NAXES-1:0]          run_req,
	input wire logic                      flash_fail,
	input wire psie_ll_type               ll_evt,
	input wire logic [NAXES-1:0]          prog_start_q,
	input wire logic [NAXES-1:0]          fast_stop_q,
	input wire logic                      mod_err_q
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire psie_axis_type a  = axis[0];   // Axis 0 state
	wire                r0 = run_req[0]; // Axis 0 request
	// Nothing blocks the start
	wire ok = !a.homing && !a.jogging && !a.cmd_valid && !a.prog_active && !a.abort_req
		&& !a.moving && a.pos_valid && a.drive_en;
	property p_go;    r0 && ok |-> ##[1:3] prog_start_q[0]; endproperty
	property p_home;  r0 && a.homing |=> !prog_start_q[0] [*3]; endproperty
	property p_jog;   r0 && a.jogging |=> !prog_start_q[0] [*3]; endproperty
	property p_pact;  r0 && a.prog_active |=> !prog_start_q[0] [*3]; endproperty
	property p_posv;  r0 && !a.pos_valid |=> !prog_start_q[0] [*3]; endproperty
	property p_drv;   r0 && !a.drive_en |=> !prog_start_q[0] [*3]; endproperty
	property p_halt;  ll_evt.halt_wr |-> ##[1:3] (&fast_stop_q); endproperty
	property p_flash; flash_fail |-> ##[1:3] mod_err_q; endproperty
	a_go: assert property (p_go) else $error("clean request not started");
	a_home: assert property (p_home) else $error("started while homing");
	a_jog: assert property (p_jog) else $error("started while jogging");
	a_pact: assert property (p_pact) else $error("started over active program");
	a_posv: assert property (p_posv) else $error("started without position");
	a_drv: assert property (p_drv) else $error("started without drive");
	a_halt: assert property (p_halt) else $error("halt without fast stop");
	a_flash: assert property (p_flash) else $error("flash fault not flagged");
	c_go: cover property (r0 && ok ##[1:3] prog_start_q[0]);
	c_home: cover property (r0 && a.homing);
	c_zero: cover property (ll_evt.div_zero);
endmodule
`default_nettype wire

/* File: tb/psie_host_model.sv */
`default_nettype none
// ==========================================
// Host side: axis status levels and run pulses
module psie_host
	import psie_pkg::*;
#(
	parameter int NAXES = 2
)(
	input  wire logic                      sys_clk,
	output var  psie_axis_type [NAXES-1:0] axis,
	output var  logic [NAXES-1:0]          run_req
);
	timeunit 1ns;
	timeprecision 1ns;
	// Ready axis: jog, homing and moves all ended
	function automatic psie_axis_type idle();
		idle = '0;
		idle.pos_valid = 1'b1;
		idle.drive_en  = 1'b1;
	endfunction
	initial begin
		axis    = {NAXES{idle()}};
		run_req = '0;
	end
	// One-cycle request with the given state
	task req(input int n, input psie_axis_type st);
		@(posedge sys_clk);
		axis[n]    <= st;
		run_req[n] <= 1'b1;
		@(posedge sys_clk);
		run_req[n] <= 1'b0;
		axis[n]    <= idle();
	endtask
endmodule
`default_nettype wire

/* File: tb/tb_program_start_interlock_errors.sv */
`default_nettype none
`include "psie_defines.svh"
module tb_program_start_interlock_errors;
	import psie_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mod_err_q;
	logic [3:0]  wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [9:0]  ev;           // Event pulses driven here
	logic [1:0]  run_req, prog_start_q, fast_stop_q;
	psie_axis_type [1:0] axis;
	psie_axis_type st;
	int compares, miscompares, cyc_n, i;
	logic [7:0] codes [9] = '{`PSIE_ERR_HOME, `PSIE_ERR_JOG, `PSIE_ERR_VEL,
		`PSIE_ERR_FORCE, `PSIE_ERR_PROG, `PSIE_ERR_ABORT, `PSIE_ERR_POSV,
		`PSIE_ERR_DRIVE, `PSIE_ERR_FORCE};
	logic [7:0] fat [4] = '{`PSIE_ERR_HALT, `PSIE_ERR_DIVZERO, `PSIE_ERR_DIVOVF,
		`PSIE_ERR_TIMEOUT};
	psie_top #(.NAXES(2), .LL_BUDGET(20)) dut (.sys_clk(sys_clk), .reset(reset),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.axis(axis), .run_req(run_req), .sync_cm_err(ev[1:0]), .sync_jmp_err(ev[3:2]),
		.flash_fail(ev[4]), .ll_evt(ev[7:5]), .ll_cycle_start(ev[8]),
		.ll_cycle_done(ev[9]), .prog_start_q(prog_start_q), .fast_stop_q(fast_stop_q),
		.mod_err_q(mod_err_q));
	psie_host #(.NAXES(2)) host (.sys_clk(sys_clk), .axis(axis), .run_req(run_req));
	always #10 sys_clk = ~sys_clk;
	// Hang guard
	always @(posedge sys_clk) begin
		cyc_n++;
		if (cyc_n > 5000) begin
			miscompares++;
			finish_test();
		end
	end
	task finish_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// Classic Wishbone single cycle
	task wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= ad;
		wb_dat_i <= d;
		@(posedge sys_clk);
		while (wb_ack_o !== 1'b1) @(posedge sys_clk);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task rd(input logic [3:0] ad, input logic [7:0] exp);
		wb(1'b0, ad, 32'h0);
		chk(q, {24'h0, exp});
	endtask
	task pulse(input int b);
		@(posedge sys_clk);
		ev[b] <= 1'b1;
		@(posedge sys_clk);
		ev[b] <= 1'b0;
	endtask
	initial begin
		{sys_clk, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, ev} = '0;
		reset = 1'b1;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		// Each blocker except moving alone on axis 0
		for (i = 0; i < 9; i++) begin
			st = host.idle();
			case (i)
				0: st.homing = 1'b1;
				1: st.jogging = 1'b1;
				2: st.active_cmd = `PSIE_CMD_VEL;
				3: st.active_cmd = `PSIE_CMD_FORCE_DV;
				4: st.prog_active = 1'b1;
				5: st.abort_req = 1'b1;
				6: st.pos_valid = 1'b0;
				7: st.drive_en = 1'b0;
				8: st.active_cmd = `PSIE_CMD_FORCE_AN;
			endcase
			st.cmd_valid = (i == 2 || i == 3 || i == 8);
			host.req(0, st);
			rd(4'h0, codes[i]);
			chk(fast_stop_q, 2'b00);
		end
		wb(1'b1, 4'h3, 32'h1);
		host.req(0, host.idle());
		// Count start pulses: a clean request gives exactly one
		q = 32'h0;
		for (i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			q = q + 32'(prog_start_q[0]);
		end
		chk(q, 32'h1);
		rd(4'h0, `PSIE_ERR_NONE);
		pulse(1);
		rd(4'h3, `PSIE_ERR_SYNC_CM);
		pulse(2);
		rd(4'h0, `PSIE_ERR_SYNC_JMP);
		chk(fast_stop_q, 2'b00);
		pulse(4);
		rd(4'h1, `PSIE_ERR_FLASH);
		chk(mod_err_q, 1'b1);
		rd(4'h7, 8'h00);
		wb(1'b1, 4'h3, 32'h1);
		pulse(8);
		repeat (5) @(posedge sys_clk);
		pulse(9);
		rd(4'h1, `PSIE_ERR_NONE);
		// Fatal user-logic faults, last one a missed cycle end
		for (i = 0; i < 4; i++) begin
			if (i < 3)
				pulse(7 - i);
			else begin
				pulse(8);
				repeat (30) @(posedge sys_clk);
			end
			rd(4'h1, fat[i]);
			rd(4'h3, `PSIE_ERR_LLSTOP);
			rd(4'h0, `PSIE_ERR_LLSTOP);
			chk(fast_stop_q, 2'b11);
			rd(4'h2, 8'h01);
			wb(1'b1, 4'h3, 32'h1);
			// Clear reaches the stop output two edges after ack
			repeat (2) @(posedge sys_clk);
			chk(fast_stop_q, 2'b00);
		end
		finish_test();
	end
endmodule
bind psie_top psie_props #(.NAXES(NAXES)) u_props (.sys_clk(sys_clk), .reset(reset),
	.axis(axis), .run_req(run_req), .flash_fail(flash_fail), .ll_evt(ll_evt),
	.prog_start_q(prog_start_q), .fast_stop_q(fast_stop_q), .mod_err_q(mod_err_q));
`default_nettype wire
